//--- src/sisl_pkg.sv
package sisl_pkg;

   // Register offsets reached over the serial port.
   localparam logic [7:0] ADDR_FLAGS_PRI   = 8'h00;
   localparam logic [7:0] ADDR_FLAGS_SEC   = 8'h01;
   localparam logic [7:0] ADDR_ENABLES_PRI = 8'h02;
   localparam logic [7:0] ADDR_ENABLES_SEC = 8'h03;

   // Reset values, the primary enable write mask and the read value of unused offsets.
   localparam logic [7:0] FLAGS_PRI_RST    = 8'h00;
   localparam logic       FLAGS_SEC_RST    = 1'b0;
   localparam logic [7:0] ENABLES_PRI_RST  = 8'h00;
   localparam logic       ENABLES_SEC_RST  = 1'b0;
   localparam logic [7:0] ENABLES_PRI_MASK = 8'hfe;
   localparam logic [7:0] READ_ZERO        = 8'h00;

   // Bit positions inside the primary flag and enable registers; BIT_AUTH_DONE is bit 0 of the secondary flag register.
   localparam int BIT_ALMOST_FULL  = 7;
   localparam int BIT_NEW_SAMPLE   = 6;
   localparam int BIT_AMB_OVF      = 5;
   localparam int BIT_PROX         = 4;
   localparam int BIT_NONCOMPLY    = 3;
   localparam int BIT_TEMP_DONE    = 2;
   localparam int BIT_SUPPLY_RANGE = 1;
   localparam int BIT_UNDERVOLT    = 0;
   localparam int BIT_AUTH_DONE    = 0;

   // Serial frame: address byte, command byte, data byte.
   localparam logic [4:0] SPI_ADDR_END  = 5'd7;
   localparam logic [4:0] SPI_CMD_END   = 5'd15;
   localparam logic [4:0] SPI_DATA_END  = 5'd23;
   localparam logic [4:0] SPI_CNT_MAX   = 5'd24;
   localparam int         SPI_READ_BIT  = 7;

   // FIFO depth and proximity threshold scale.
   localparam logic [7:0] FIFO_DEPTH      = 8'd128;
   localparam int         PROX_SCALE_BITS = 11;

   // Supply range detection delay.
   localparam int SYS_CLK_HZ      = 25000000;
   localparam int SUPPLY_DELAY_MS = 10;
   localparam int SUPPLY_DELAY_CYCLES =
      SUPPLY_DELAY_MS * (SYS_CLK_HZ / 1000);

   // Synchroniser lanes.
   localparam int SYNC_ADDR   = 0;
   localparam int SYNC_RD     = 1;
   localparam int SYNC_WR     = 2;
   localparam int SYNC_SUPPLY = 3;
   localparam int SYNC_LANES  = 4;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
   } sisl_spi_req_t;

   typedef struct packed {
      logic sample_written;
      logic fifo_data_read;
      logic amb_saturated;
      logic slot1_adc_valid;
      logic sample_end;
      logic led_noncompliant;
      logic temp_done;
      logic temp_result_read;
      logic undervolt_event;
      logic shutdown_write;
      logic auth_done;
   } sisl_events_t;

endpackage : sisl_pkg

//--- src/sisl_spi_front.sv
`timescale 1ns/1ps
`default_nettype none

// Serial port front end on the serial clock. A frame is address byte,
// command byte (bit 7 set for a read) and one data byte, mode 0, MSB first.
// Chip select high resets the frame state, so each frame starts clean; the
// captured request is kept until the next frame overwrites it.
module sisl_spi_front (
   input  wire logic                   spi_sclk_i,
   input  wire logic                   spi_csb_n_i,
   input  wire logic                   spi_mosi_i,
   input  wire logic [7:0]             rd_data_i,
   output sisl_pkg::sisl_spi_req_t     req_o,
   output logic                        addr_vld_o,
   output logic                        rd_cmd_o,
   output logic                        wr_done_o,
   output logic                        spi_miso_o,
   output logic                        spi_miso_oe_o
);
   import sisl_pkg::*;

   logic [4:0]    cnt_reg,      cnt_next;
   logic [6:0]    shift_reg,    shift_next;
   sisl_spi_req_t req_reg,      req_next;
   logic          addr_vld_reg, addr_vld_next;
   logic          rd_cmd_reg,   rd_cmd_next;
   logic          wr_done_reg,  wr_done_next;
   logic          miso_reg;
   logic [7:0]    byte_in;

   always_comb begin
      byte_in       = {shift_reg, spi_mosi_i};
      shift_next    = byte_in[6:0];
      cnt_next      = (cnt_reg == SPI_CNT_MAX) ? cnt_reg : cnt_reg + 5'd1;
      req_next      = req_reg;
      addr_vld_next = addr_vld_reg;
      rd_cmd_next   = rd_cmd_reg;
      wr_done_next  = wr_done_reg;
      if (cnt_reg == SPI_ADDR_END) begin
         req_next.addr = byte_in;
         addr_vld_next = 1'b1;
      end
      if (cnt_reg == SPI_CMD_END) begin
         rd_cmd_next = byte_in[SPI_READ_BIT];
      end
      if (cnt_reg == SPI_DATA_END && !rd_cmd_reg) begin
         req_next.wdata = byte_in;
         wr_done_next   = 1'b1;
      end
   end

   always_ff @(posedge spi_sclk_i or posedge spi_csb_n_i) begin
      if (spi_csb_n_i) begin
         cnt_reg      <= 5'd0;
         shift_reg    <= 7'h00;
         addr_vld_reg <= 1'b0;
         rd_cmd_reg   <= 1'b0;
         wr_done_reg  <= 1'b0;
      end else begin
         cnt_reg      <= cnt_next;
         shift_reg    <= shift_next;
         addr_vld_reg <= addr_vld_next;
         rd_cmd_reg   <= rd_cmd_next;
         wr_done_reg  <= wr_done_next;
      end
   end

   // The request outlives chip select: the system side only sees the write
   // strobe a few of its cycles later and must still find address and data.
   always_ff @(posedge spi_sclk_i) begin
      req_reg <= req_next;
   end

   // The read byte was captured in the system domain well before the
   // command byte ends and stays still until the next frame.
   always_ff @(negedge spi_sclk_i or posedge spi_csb_n_i) begin
      if (spi_csb_n_i) begin
         miso_reg <= 1'b0;
      end else if (rd_cmd_reg) begin
         miso_reg <= rd_data_i[3'd7 - cnt_reg[2:0]];
      end
   end

   assign req_o         = req_reg;
   assign addr_vld_o    = addr_vld_reg;
   assign rd_cmd_o      = rd_cmd_reg;
   assign wr_done_o     = wr_done_reg;
   assign spi_miso_o    = miso_reg;
   assign spi_miso_oe_o = ~spi_csb_n_i & rd_cmd_reg;

endmodule : sisl_spi_front
`default_nettype wire

//--- src/sisl_top.sv
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// (RULE1) Set flag bit 7 when a stored sample reaches the almost-full level.
// (RULE2) Bit 7 clears on primary flag read, or FIFO data read if enabled.
// (RULE3) Set flag bit 6 whenever a new sample enters the FIFO.
// (RULE4) Bit 6 clears on primary flag read, or FIFO data read if enabled.
// (RULE5) Bit 5 sets on ambient cancel saturation; only a flag read clears.
// (RULE6) Bit 4 sets on proximity crossing of slot one; flag read clears.
// (RULE7) Proximity enable low forces normal mode: full sequence, no gating.
// (RULE8) At sample end, noncompliant LED with enable set raises bit 3.
// (RULE9) Bit 2 sets on temperature done; clears on result or flag read.
// (RULE10) Bit 1 raises after 10 ms out of range, retriggers, clears on read.
// (RULE11) Bit 0 records undervoltage; clears on flag read or shutdown write.
// (RULE12) Secondary bit 0 sets on authentication done; clears on its read.
// (RULE13) Primary enable bits 7..1 read-write, reset zero; bit 0 reads zero.
// (RULE14) Slot one reading below threshold times 2048 means proximity mode.
// (RULE15) With proximity on, each mode change raises the proximity flag.
// (RULE16) Interrupt is high while any set flag has its enable bit set.
// (RULE17) Read clears only returned flags; same-cycle events stay set.
module sisl_top #(
   parameter int unsigned SUPPLY_DELAY_CYCLES = sisl_pkg::SUPPLY_DELAY_CYCLES
) (
   input  wire logic                   sys_clk_i,
   input  wire logic                   srst_i,
   input  wire logic                   spi_sclk_i,
   input  wire logic                   spi_csb_n_i,
   input  wire logic                   spi_mosi_i,
   output logic                        spi_miso_o,
   output logic                        spi_miso_oe_o,
   input  wire sisl_pkg::sisl_events_t ev_i,
   input  wire logic [7:0]             fifo_count_i,
   input  wire logic [6:0]             almost_full_thr_i,
   input  wire logic                   read_clears_status_i,
   input  wire logic [18:0]            slot1_adc_i,
   input  wire logic [7:0]             prox_thresh_i,
   input  wire logic                   supply_out_of_range_i,
   output logic                        prox_mode_o,
   output logic                        irq_o
);
   import sisl_pkg::*;

   localparam int CW = $clog2(SUPPLY_DELAY_CYCLES + 1);
   localparam logic [CW-1:0] SUPPLY_LAST = CW'(SUPPLY_DELAY_CYCLES - 1);

   sisl_spi_req_t   spi_req;
   logic            spi_addr_vld;
   logic            spi_rd_cmd;
   logic            spi_wr_done;

   logic [SYNC_LANES-1:0] sync1_reg;
   logic [SYNC_LANES-1:0] sync2_reg;
   logic [SYNC_LANES-1:0] sync3_reg;
   logic                  addr_rise;
   logic                  rd_rise;
   logic                  wr_rise;
   logic                  supply_bad;

   logic [7:0]    flags_pri_reg,   flags_pri_next;
   logic          flags_sec_reg,   flags_sec_next;
   logic [7:0]    enables_pri_reg, enables_pri_next;
   logic          enables_sec_reg, enables_sec_next;
   logic [7:0]    rd_data_reg,     rd_data_next;
   logic [7:0]    snap_pri_reg,    snap_pri_next;
   logic          snap_sec_reg,    snap_sec_next;
   logic          prox_mode_reg,   prox_mode_next;
   logic [CW-1:0] supply_cnt_reg,  supply_cnt_next;

   logic [7:0]    set_pri;
   logic [7:0]    clr_pri;
   logic          prox_below;
   logic          supply_hit;
   logic          fifo_clr;

   sisl_spi_front u_front (
      .spi_sclk_i    (spi_sclk_i),
      .spi_csb_n_i   (spi_csb_n_i),
      .spi_mosi_i    (spi_mosi_i),
      .rd_data_i     (rd_data_reg),
      .req_o         (spi_req),
      .addr_vld_o    (spi_addr_vld),
      .rd_cmd_o      (spi_rd_cmd),
      .wr_done_o     (spi_wr_done),
      .spi_miso_o    (spi_miso_o),
      .spi_miso_oe_o (spi_miso_oe_o)
   );

   // Two-flop synchronisers; the third stage only serves edge detection.
   genvar gi;
   generate
      for (gi = 0; gi < SYNC_LANES; gi++) begin : g_sync
         logic src;
         if (gi == SYNC_ADDR) begin : g_a
            assign src = spi_addr_vld;
         end else if (gi == SYNC_RD) begin : g_r
            assign src = spi_rd_cmd;
         end else if (gi == SYNC_WR) begin : g_w
            assign src = spi_wr_done;
         end else begin : g_s
            assign src = supply_out_of_range_i;
         end
         always_ff @(posedge sys_clk_i) begin
            if (srst_i) begin
               sync1_reg[gi] <= 1'b0;
               sync2_reg[gi] <= 1'b0;
               sync3_reg[gi] <= 1'b0;
            end else begin
               sync1_reg[gi] <= src;
               sync2_reg[gi] <= sync1_reg[gi];
               sync3_reg[gi] <= sync2_reg[gi];
            end
         end
      end
   endgenerate

   assign addr_rise  = sync2_reg[SYNC_ADDR] & ~sync3_reg[SYNC_ADDR];
   assign rd_rise    = sync2_reg[SYNC_RD] & ~sync3_reg[SYNC_RD];
   assign wr_rise    = sync2_reg[SYNC_WR] & ~sync3_reg[SYNC_WR];
   assign supply_bad = sync2_reg[SYNC_SUPPLY];

   always_comb begin
      // Proximity mode tracking.
      prox_below     = slot1_adc_i < {prox_thresh_i, {PROX_SCALE_BITS{1'b0}}}; // RULE14
      prox_mode_next = prox_mode_reg;
      if (!enables_pri_reg[BIT_PROX]) begin
         prox_mode_next = 1'b0; // RULE7
      end else if (ev_i.slot1_adc_valid) begin
         prox_mode_next = prox_below; // RULE14
      end

      // Supply range detection delay, restarting while out of range.
      supply_hit      = 1'b0;
      supply_cnt_next = '0;
      if (supply_bad) begin
         if (supply_cnt_reg == SUPPLY_LAST) begin
            supply_hit = 1'b1; // RULE10
         end else begin
            supply_cnt_next = supply_cnt_reg + CW'(1);
         end
      end

      set_pri = 8'h00;
      set_pri[BIT_ALMOST_FULL] = ev_i.sample_written &&
         (fifo_count_i >= FIFO_DEPTH - {1'b0, almost_full_thr_i}); // RULE1
      set_pri[BIT_NEW_SAMPLE] = ev_i.sample_written; // RULE3
      set_pri[BIT_AMB_OVF]    = ev_i.amb_saturated; // RULE5
      set_pri[BIT_PROX]       = enables_pri_reg[BIT_PROX] &&
         ev_i.slot1_adc_valid && (prox_below != prox_mode_reg); // RULE6 RULE15
      set_pri[BIT_NONCOMPLY]  = ev_i.sample_end && ev_i.led_noncompliant &&
         enables_pri_reg[BIT_NONCOMPLY]; // RULE8
      set_pri[BIT_TEMP_DONE]  = ev_i.temp_done; // RULE9
      set_pri[BIT_SUPPLY_RANGE] = supply_hit; // RULE10
      set_pri[BIT_UNDERVOLT]  = ev_i.undervolt_event; // RULE11

      // Clears: the bits returned by the committed read, plus the FIFO, temperature and shutdown clears.
      clr_pri  = rd_rise ? snap_pri_reg : 8'h00; // RULE17
      fifo_clr = read_clears_status_i && ev_i.fifo_data_read;
      clr_pri[BIT_ALMOST_FULL] = clr_pri[BIT_ALMOST_FULL] | fifo_clr; // RULE2
      clr_pri[BIT_NEW_SAMPLE]  = clr_pri[BIT_NEW_SAMPLE] | fifo_clr; // RULE4
      clr_pri[BIT_TEMP_DONE]   = clr_pri[BIT_TEMP_DONE] |
         ev_i.temp_result_read; // RULE9
      clr_pri[BIT_UNDERVOLT]   = clr_pri[BIT_UNDERVOLT] |
         ev_i.shutdown_write; // RULE11

      flags_pri_next = (flags_pri_reg & ~clr_pri) | set_pri; // RULE17
      flags_sec_next = (flags_sec_reg & ~(rd_rise & snap_sec_reg)) |
         ev_i.auth_done; // RULE12

      // Register writes.
      enables_pri_next = enables_pri_reg;
      enables_sec_next = enables_sec_reg;
      if (wr_rise && spi_req.addr == ADDR_ENABLES_PRI) begin
         enables_pri_next = spi_req.wdata & ENABLES_PRI_MASK; // RULE13
      end
      if (wr_rise && spi_req.addr == ADDR_ENABLES_SEC) begin
         enables_sec_next = spi_req.wdata[0];
      end

      // Read capture once the address is known; clearing waits for commit.
      rd_data_next  = rd_data_reg;
      snap_pri_next = snap_pri_reg;
      snap_sec_next = snap_sec_reg;
      if (addr_rise) begin
         snap_pri_next = 8'h00;
         snap_sec_next = 1'b0;
         unique case (spi_req.addr)
            ADDR_FLAGS_PRI: begin
               rd_data_next  = flags_pri_reg;
               snap_pri_next = flags_pri_reg;
            end
            ADDR_FLAGS_SEC: begin
               rd_data_next  = {7'h00, flags_sec_reg};
               snap_sec_next = flags_sec_reg;
            end
            ADDR_ENABLES_PRI: rd_data_next = enables_pri_reg;
            ADDR_ENABLES_SEC: rd_data_next = {7'h00, enables_sec_reg};
            default:          rd_data_next = READ_ZERO;
         endcase
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         flags_pri_reg   <= FLAGS_PRI_RST;
         flags_sec_reg   <= FLAGS_SEC_RST;
         enables_pri_reg <= ENABLES_PRI_RST;
         enables_sec_reg <= ENABLES_SEC_RST;
         rd_data_reg     <= READ_ZERO;
         snap_pri_reg    <= 8'h00;
         snap_sec_reg    <= 1'b0;
         prox_mode_reg   <= 1'b0;
         supply_cnt_reg  <= '0;
      end else begin
         flags_pri_reg   <= flags_pri_next;
         flags_sec_reg   <= flags_sec_next;
         enables_pri_reg <= enables_pri_next;
         enables_sec_reg <= enables_sec_next;
         rd_data_reg     <= rd_data_next;
         snap_pri_reg    <= snap_pri_next;
         snap_sec_reg    <= snap_sec_next;
         prox_mode_reg   <= prox_mode_next;
         supply_cnt_reg  <= supply_cnt_next;
      end
   end

   assign prox_mode_o = prox_mode_reg; // RULE7
   assign irq_o = |(flags_pri_reg & enables_pri_reg) |
                  (flags_sec_reg & enables_sec_reg); // RULE16

   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (srst_i);

   a_almost_full_set: assert property ( // RULE1
      ev_i.sample_written &&
      fifo_count_i >= FIFO_DEPTH - {1'b0, almost_full_thr_i}
      |=> flags_pri_reg[BIT_ALMOST_FULL])
      else $error("Almost-full flag not set at the threshold.");
   a_fifo_read_clr: assert property ( // RULE2
      read_clears_status_i && ev_i.fifo_data_read && !ev_i.sample_written
      |=> !flags_pri_reg[BIT_ALMOST_FULL] && !flags_pri_reg[BIT_NEW_SAMPLE])
      else $error("FIFO data read did not clear the FIFO flags.");
   a_sample_wins: assert property ( // RULE3
      ev_i.sample_written |=> flags_pri_reg[BIT_NEW_SAMPLE])
      else $error("New-sample event lost.");
   a_fifo_keep: assert property ( // RULE4
      !read_clears_status_i && !rd_rise && flags_pri_reg[BIT_NEW_SAMPLE]
      |=> flags_pri_reg[BIT_NEW_SAMPLE])
      else $error("New-sample flag cleared without a read.");
   a_amb_only_read: assert property ( // RULE5
      $fell(flags_pri_reg[BIT_AMB_OVF]) |-> $past(rd_rise))
      else $error("Ambient overflow flag cleared without a read.");
   a_prox_trans: assert property ( // RULE15
      enables_pri_reg[BIT_PROX] && ev_i.slot1_adc_valid &&
      (prox_below != prox_mode_reg)
      |=> flags_pri_reg[BIT_PROX] && prox_mode_reg == $past(prox_below))
      else $error("Proximity transition not flagged.");
   a_prox_off: assert property ( // RULE7
      !enables_pri_reg[BIT_PROX] |=> !prox_mode_o)
      else $error("Proximity mode held while disabled.");
   a_noncomply: assert property ( // RULE8
      ev_i.sample_end && ev_i.led_noncompliant && enables_pri_reg[BIT_NONCOMPLY]
      |=> flags_pri_reg[BIT_NONCOMPLY])
      else $error("Noncompliance not flagged at sample end.");
   a_temp_clear: assert property ( // RULE9
      ev_i.temp_result_read && !ev_i.temp_done
      |=> !flags_pri_reg[BIT_TEMP_DONE])
      else $error("Temperature result read did not clear the flag.");
   a_supply_delay: assert property ( // RULE10
      supply_bad && supply_cnt_reg == SUPPLY_LAST
      |=> flags_pri_reg[BIT_SUPPLY_RANGE] && supply_cnt_reg == '0)
      else $error("Supply flag not raised after the delay.");
   a_shutdown_clr: assert property ( // RULE11
      ev_i.shutdown_write && !ev_i.undervolt_event
      |=> !flags_pri_reg[BIT_UNDERVOLT])
      else $error("Shutdown write did not clear the undervoltage flag.");
   a_auth_set: assert property ( // RULE12
      ev_i.auth_done |=> flags_sec_reg)
      else $error("Authentication done not flagged.");
   a_enable_bit0: assert property ( // RULE13
      enables_pri_reg[0] == 1'b0)
      else $error("Reserved enable bit became set.");
   a_irq_follow: assert property ( // RULE16
      $rose(flags_pri_reg[BIT_NEW_SAMPLE]) && enables_pri_reg[BIT_NEW_SAMPLE]
      |-> irq_o)
      else $error("Interrupt not raised for an enabled flag.");
   a_read_clears: assert property ( // RULE17
      rd_rise && snap_pri_reg[BIT_AMB_OVF] && !ev_i.amb_saturated
      |=> !flags_pri_reg[BIT_AMB_OVF])
      else $error("Flag returned by a read was not cleared.");
   a_prox_level: assert property ( // RULE14
      enables_pri_reg[BIT_PROX] && ev_i.slot1_adc_valid
      |=> prox_mode_o == ($past(slot1_adc_i) < $past(prox_thresh_i) * 2048))
      else $error("Proximity mode does not follow the threshold.");

   c_flag_read:  cover property (rd_rise && snap_pri_reg != 8'h00);
   c_enable_wr:  cover property (wr_rise && spi_req.addr == ADDR_ENABLES_PRI);
   c_prox_flag:  cover property (set_pri[BIT_PROX]);
   c_supply_hit: cover property (supply_hit);
   c_auth_irq:   cover property (flags_sec_reg && enables_sec_reg);

endmodule : sisl_top
`default_nettype wire

//--- tb/sisl_host.sv
`timescale 1ns/1ps
`default_nettype none

// Host processor on the serial port: mode 0, MSB first, 80 ns serial period.
module sisl_host (
   output logic      sclk_o,
   output logic      csb_n_o,
   output logic      mosi_o,
   input  wire logic miso_i,
   input  wire logic miso_oe_i
);
   // Chip select starts with a rising edge so that the serial side's frame-state flops
   // leave their unknown power-up state before the first frame.
   initial begin
      sclk_o  = 1'b0;
      csb_n_o = 1'b0;
      mosi_o  = 1'b0;
      #5;
      csb_n_o = 1'b1;
   end

   // The odd start offset keeps serial edges off the system clock edges.
   // A bit that arrives with the output enable low is taken as unknown.
   task automatic access(input logic [7:0] addr, input logic rd,
                         input logic [7:0] wd, output logic [7:0] rdat);
      logic [23:0] sh;
      sh   = {addr, rd, 7'h00, wd};
      rdat = 8'h00;
      #17;
      csb_n_o = 1'b0;
      for (int i = 23; i >= 0; i--) begin
         mosi_o = sh[i];
         #40;
         sclk_o = 1'b1;
         if (i < 8) begin
            rdat = {rdat[6:0], miso_oe_i ? miso_i : 1'bx};
         end
         #40;
         sclk_o = 1'b0;
      end
      #40;
      csb_n_o = 1'b1;
      mosi_o  = ~mosi_o;
      #200;
   endtask : access
endmodule : sisl_host

`default_nettype wire

//--- tb/sisl_top_tb.sv
`timescale 1ns/1ps
`default_nettype none

module sisl_top_tb;
   import sisl_pkg::*;

   localparam logic [10:0] E_WR = 11'h400, E_FRD = 11'h200, E_AMB = 11'h100;
   localparam logic [10:0] E_ADC = 11'h080, E_END = 11'h040, E_NC = 11'h020;
   localparam logic [10:0] E_TMP = 11'h010, E_TRD = 11'h008, E_UV = 11'h004;
   localparam logic [10:0] E_SHD = 11'h002, E_AUTH = 11'h001;

   logic         sys_clk, srst, sclk, csb_n, mosi, miso, miso_oe;
   logic         rcs, sup, prox_mode, irq;
   sisl_events_t ev;
   logic [7:0]   cnt, pthr, dummy;
   logic [6:0]   afthr;
   logic [18:0]  adc;
   int           n_fail, checked, cycles;
   logic [10:0]  tab_ev [4];
   logic [7:0]   tab_fl [4];

   sisl_top #(.SUPPLY_DELAY_CYCLES(20)) sisl_top_inst (
      .sys_clk_i(sys_clk), .srst_i(srst), .spi_sclk_i(sclk),
      .spi_csb_n_i(csb_n), .spi_mosi_i(mosi), .spi_miso_o(miso),
      .spi_miso_oe_o(miso_oe), .ev_i(ev), .fifo_count_i(cnt),
      .almost_full_thr_i(afthr), .read_clears_status_i(rcs),
      .slot1_adc_i(adc), .prox_thresh_i(pthr),
      .supply_out_of_range_i(sup), .prox_mode_o(prox_mode), .irq_o(irq)
   );

   sisl_host sisl_host_inst (
      .sclk_o(sclk), .csb_n_o(csb_n), .mosi_o(mosi),
      .miso_i(miso), .miso_oe_i(miso_oe)
   );

   initial sys_clk = 1'b0;
   always #20 sys_clk = ~sys_clk;

   task automatic complete_run;
      if (n_fail == 0 && checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : complete_run

   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 8000) begin
         n_fail++;
         complete_run();
      end
   end

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      sisl_host_inst.access(a, 1'b1, 8'h00, d);
      chk(d, exp);
   endtask : rd

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      sisl_host_inst.access(a, 1'b0, d, dummy);
   endtask : wr

   // One-cycle event pulse; the flag is settled at the closing falling edge.
   task automatic pulse(input logic [10:0] e);
      @(negedge sys_clk);
      ev = sisl_events_t'(e);
      @(negedge sys_clk);
      ev = '0;
   endtask : pulse

   initial begin
      n_fail = 0;
      checked = 0;
      cycles = 0;
      srst = 1'b1;
      ev = '0;
      cnt = 8'h00;
      afthr = 7'h0f;
      rcs = 1'b0;
      adc = '0;
      pthr = 8'h01;
      sup = 1'b0;
      tab_ev = '{E_WR, E_AMB, E_TMP, E_UV};
      tab_fl = '{8'h40, 8'h20, 8'h04, 8'h01};
      repeat (3) @(negedge sys_clk);
      srst = 1'b0;
      repeat (6) @(negedge sys_clk);
      rd(ADDR_FLAGS_PRI, FLAGS_PRI_RST);
      rd(ADDR_FLAGS_SEC, 8'h00);
      rd(ADDR_ENABLES_PRI, ENABLES_PRI_RST);
      rd(8'h10, READ_ZERO);
      wr(ADDR_ENABLES_PRI, 8'hff);
      rd(ADDR_ENABLES_PRI, 8'hfe);
      wr(ADDR_FLAGS_PRI, 8'hff);
      rd(ADDR_FLAGS_PRI, 8'h00);
      wr(ADDR_ENABLES_PRI, 8'h00);
      for (int i = 0; i < 4; i++) begin
         pulse(tab_ev[i]);
         rd(ADDR_FLAGS_PRI, tab_fl[i]);
         rd(ADDR_FLAGS_PRI, 8'h00);
      end
      pulse(E_AUTH);
      rd(ADDR_FLAGS_SEC, 8'h01);
      rd(ADDR_FLAGS_SEC, 8'h00);
      pulse(E_END | E_NC);
      rd(ADDR_FLAGS_PRI, 8'h00);
      wr(ADDR_ENABLES_PRI, 8'h08);
      pulse(E_NC);
      pulse(E_END | E_NC);
      rd(ADDR_FLAGS_PRI, 8'h08);
      pulse(E_END);
      rd(ADDR_FLAGS_PRI, 8'h00);
      @(negedge sys_clk) cnt = 8'd112;
      pulse(E_WR);
      rd(ADDR_FLAGS_PRI, 8'h40);
      @(negedge sys_clk) cnt = 8'd113;
      pulse(E_WR);
      rd(ADDR_FLAGS_PRI, 8'hc0);
      pulse(E_WR | E_AMB);
      pulse(E_FRD);
      rd(ADDR_FLAGS_PRI, 8'he0);
      @(negedge sys_clk) rcs = 1'b1;
      pulse(E_WR | E_AMB);
      pulse(E_FRD);
      rd(ADDR_FLAGS_PRI, 8'h20);
      @(negedge sys_clk) rcs = 1'b0;
      pulse(E_TMP);
      pulse(E_TRD);
      rd(ADDR_FLAGS_PRI, 8'h00);
      pulse(E_UV);
      pulse(E_SHD);
      rd(ADDR_FLAGS_PRI, 8'h00);
      @(negedge sys_clk) cnt = 8'h00;
      wr(ADDR_ENABLES_PRI, 8'h40);
      pulse(E_WR | E_AMB);
      chk({7'h00, irq}, 8'h01);
      wr(ADDR_ENABLES_PRI, 8'h20);
      chk({7'h00, irq}, 8'h01);
      wr(ADDR_ENABLES_PRI, 8'h80);
      chk({7'h00, irq}, 8'h00);
      rd(ADDR_FLAGS_PRI, 8'h60);
      wr(ADDR_ENABLES_PRI, 8'h10);
      @(negedge sys_clk) adc = 19'd2047;
      pulse(E_ADC);
      chk({7'h00, prox_mode}, 8'h01);
      chk({7'h00, irq}, 8'h01);
      rd(ADDR_FLAGS_PRI, 8'h10);
      @(negedge sys_clk) adc = 19'd2048;
      pulse(E_ADC);
      chk({7'h00, prox_mode}, 8'h00);
      pulse(E_ADC);
      rd(ADDR_FLAGS_PRI, 8'h10);
      rd(ADDR_FLAGS_PRI, 8'h00);
      @(negedge sys_clk) adc = 19'd5;
      pulse(E_ADC);
      chk({7'h00, prox_mode}, 8'h01);
      rd(ADDR_FLAGS_PRI, 8'h10);
      wr(ADDR_ENABLES_PRI, 8'h00);
      chk({7'h00, prox_mode}, 8'h00);
      pulse(E_ADC);
      chk({7'h00, prox_mode}, 8'h00);
      rd(ADDR_FLAGS_PRI, 8'h00);
      wr(ADDR_ENABLES_PRI, 8'h02);
      @(negedge sys_clk) sup = 1'b1;
      repeat (15) @(negedge sys_clk);
      chk({7'h00, irq}, 8'h00);
      repeat (10) @(negedge sys_clk);
      chk({7'h00, irq}, 8'h01);
      rd(ADDR_FLAGS_PRI, 8'h02);
      rd(ADDR_FLAGS_PRI, 8'h02);
      @(negedge sys_clk) sup = 1'b0;
      wr(8'h10, 8'h00);
      rd(ADDR_FLAGS_PRI, 8'h02);
      rd(ADDR_FLAGS_PRI, 8'h00);
      wr(ADDR_ENABLES_SEC, 8'h01);
      rd(ADDR_ENABLES_SEC, 8'h01);
      pulse(E_AUTH);
      chk({7'h00, irq}, 8'h01);
      rd(ADDR_FLAGS_SEC, 8'h01);
      chk({7'h00, irq}, 8'h00);
      complete_run();
   end
endmodule : sisl_top_tb

`default_nettype wire
